// ==== rtl/tis_supervisor.sv ====
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module tis_supervisor #(
  parameter int unsigned RESET_TICKS = tis_pkg::RESET_TICKS_DEF,
  parameter int unsigned TEMP_TICKS = tis_pkg::TEMP_TICKS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_n,
  input wire logic esd_event,
  input wire logic adc_busy,
  input wire logic temp_done,
  input wire logic [7:0] temp_celsius,
  input wire logic pen_event,
  input wire logic data_ready_event,
  input wire logic prox_event,
  input wire logic short_event,
  input wire logic pen_status,
  input wire logic prox_status,
  input wire logic short_status,
  input wire logic chan_data_read_done,
  input wire logic five_wire_sense,
  input wire logic prox_sensor_route,
  input wire logic prox_shield_route,
  output logic host_interrupt_n,
  output logic temp_start,
  output logic thermal_shutdown,
  output logic discard_results,
  output logic restart_sequence,
  output logic touch_enable,
  output logic prox_enable,
  output logic haptics_enable,
  output logic adc_halt,
  output logic aux_pin_one,
  output logic aux_pin_two,
  output logic aux_pin_three
);
  localparam logic [15:0] RESET_LAST = 16'(RESET_TICKS - 1);
  localparam logic [9:0] TEMP_LAST = 10'(TEMP_TICKS - 1);

  // slow oscillator enable
  logic [tis_pkg::DIV_W-1:0] div_q;
  logic slow_tick;
  assign slow_tick = (div_q == tis_pkg::SLOW_DIV_LAST);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (slow_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  logic external_reset_n_s1_q;
  logic external_reset_n_s2_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      external_reset_n_s1_q <= 1'b1;
      external_reset_n_s2_q <= 1'b1;
    end else begin
      external_reset_n_s1_q <= external_reset_n;
      external_reset_n_s2_q <= external_reset_n_s1_q;
    end
  end

  // apb decode
  logic setup_ph, access_done, wr_en, rd_en, mapped, soft_key;
  logic sel_mask, sel_src, sel_stat, sel_srst;
  logic sel_cfg, sel_rate, sel_aux0, sel_aux_pin_one;
  assign setup_ph = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_en = access_done && pwrite;
  assign rd_en = access_done && !pwrite;
  assign sel_mask = (paddr == tis_pkg::OFS_IRQ_MASK);
  assign sel_src = (paddr == tis_pkg::OFS_IRQ_SRC);
  assign sel_stat = (paddr == tis_pkg::OFS_STATUS);
  assign sel_srst = (paddr == tis_pkg::OFS_SOFT_RST);
  assign sel_cfg = (paddr == tis_pkg::OFS_CFG);
  assign sel_rate = (paddr == tis_pkg::OFS_RATE);
  assign sel_aux0 = (paddr == tis_pkg::OFS_AUX0);
  assign sel_aux_pin_one = (paddr == tis_pkg::OFS_AUX_PIN_ONE);
  assign mapped = sel_mask | sel_src | sel_stat | sel_srst | sel_cfg
                | sel_rate | sel_aux0 | sel_aux_pin_one;
  assign soft_key = wr_en && sel_srst && mapped
                  && (pwdata[7:0] == tis_pkg::SOFT_RESET_KEY);

  // reset procedure: busy while pin low or counter runs
  tis_pkg::tis_rst_e rst_st_q;
  logic [15:0] rst_cnt_q;
  logic rst_req, rst_busy, rst_done, flag_set;
  assign rst_req = !external_reset_n_s2_q || soft_key || esd_event;
  assign rst_busy = (rst_st_q != tis_pkg::RS_RUN);
  assign rst_done = (rst_st_q == tis_pkg::RS_COUNT) && slow_tick
                  && (rst_cnt_q == RESET_LAST);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_st_q <= tis_pkg::RS_COUNT;
      rst_cnt_q <= '0;
    end else if (rst_req) begin
      rst_st_q <= tis_pkg::RS_HOLD;
      rst_cnt_q <= '0;
    end else begin
      unique case (rst_st_q)
        tis_pkg::RS_RUN: begin
          rst_cnt_q <= '0;
        end
        tis_pkg::RS_HOLD: begin
          rst_st_q <= tis_pkg::RS_COUNT;
        end
        tis_pkg::RS_COUNT: begin
          if (rst_done) begin
            rst_st_q <= tis_pkg::RS_RUN;
          end else if (slow_tick) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
          end
        end
      endcase
    end
  end
  assign flag_set = rst_req;

  // configuration registers, defaults during any reset
  logic [7:0] mask_q, cfg_raw_q, rate_q, aux0_q, aux_pin_one_q;
  tis_pkg::tis_cfg_s cfg;
  assign cfg = tis_pkg::tis_cfg_s'(cfg_raw_q);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask_q <= tis_pkg::IRQ_MASK_RST;
      cfg_raw_q <= tis_pkg::CFG_RST;
      rate_q <= tis_pkg::RATE_RST;
      aux0_q <= tis_pkg::AUX0_RST;
      aux_pin_one_q <= tis_pkg::AUX_PIN_ONE_RST;
    end else if (rst_busy || rst_req) begin
      mask_q <= tis_pkg::IRQ_MASK_RST;
      cfg_raw_q <= tis_pkg::CFG_RST;
      rate_q <= tis_pkg::RATE_RST;
      aux0_q <= tis_pkg::AUX0_RST;
      aux_pin_one_q <= tis_pkg::AUX_PIN_ONE_RST;
    end else if (wr_en) begin
      if (sel_mask) mask_q <= pwdata[7:0];
      if (sel_cfg) cfg_raw_q <= pwdata[7:0];
      if (sel_rate) rate_q <= pwdata[7:0];
      if (sel_aux0) aux0_q <= pwdata[7:0];
      if (sel_aux_pin_one) aux_pin_one_q <= pwdata[7:0];
    end
  end

  // activity
  logic ts_on, px_on, hp_on, chip_active, sensor_on;
  assign ts_on = (cfg.op_mode != tis_pkg::MODE_MANUAL);
  assign px_on = (cfg.proximity_scan_interval != 3'h0);
  assign hp_on = (cfg.actuator_type_select != 2'h0);
  assign chip_active = ts_on || px_on || hp_on;
  assign sensor_on = cfg.thermal_monitor_continuous || chip_active;

  // measurement scheduler
  tis_pkg::tis_temp_e tst_q;
  logic [9:0] tcnt_q;
  logic period_end;
  logic may_start;
  assign period_end = slow_tick && (tcnt_q == TEMP_LAST);
  assign may_start = cfg.thermal_monitor_continuous
                   || (chip_active && !adc_busy);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tst_q <= tis_pkg::TS_WAIT;
      tcnt_q <= '0;
      temp_start <= 1'b0;
    end else if (rst_busy) begin
      tst_q <= tis_pkg::TS_WAIT;
      tcnt_q <= '0;
      temp_start <= 1'b0;
    end else begin
      temp_start <= 1'b0;
      if (period_end) begin
        tcnt_q <= '0;
      end else if (slow_tick) begin
        tcnt_q <= tcnt_q + 1'b1;
      end
      unique case (tst_q)
        tis_pkg::TS_WAIT: begin
          if (period_end && sensor_on) begin
            tst_q <= tis_pkg::TS_PEND;
          end
        end
        tis_pkg::TS_PEND: begin
          if (!sensor_on) begin
            tst_q <= tis_pkg::TS_WAIT;
          end else if (may_start) begin
            tst_q <= tis_pkg::TS_MEAS;
            temp_start <= 1'b1;
          end
        end
        tis_pkg::TS_MEAS: begin
          if (temp_done) begin
            tst_q <= tis_pkg::TS_WAIT;
          end
        end
      endcase
    end
  end

  // thermal flags and shutdown
  logic warn_q, alarm_q, warn_rise, alarm_rise, meas_ok;
  assign meas_ok = temp_done && (tst_q == tis_pkg::TS_MEAS) && !rst_busy;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      warn_q <= 1'b0;
      alarm_q <= 1'b0;
    end else if (rst_busy || !sensor_on) begin
      warn_q <= 1'b0;
      alarm_q <= 1'b0;
    end else if (meas_ok) begin
      warn_q <= (temp_celsius > tis_pkg::WARN_LEVEL_C);
      alarm_q <= (temp_celsius > tis_pkg::ALARM_LEVEL_C);
    end
  end
  assign warn_rise = meas_ok && !warn_q
                   && (temp_celsius > tis_pkg::WARN_LEVEL_C);
  assign alarm_rise = meas_ok && !alarm_q
                    && (temp_celsius > tis_pkg::ALARM_LEVEL_C);

  logic shut_leave;
  assign shut_leave = thermal_shutdown && !alarm_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      thermal_shutdown <= 1'b0;
      discard_results <= 1'b0;
      restart_sequence <= 1'b0;
      touch_enable <= 1'b0;
      prox_enable <= 1'b0;
      haptics_enable <= 1'b0;
    end else begin
      thermal_shutdown <= alarm_q;
      discard_results <= alarm_q && !thermal_shutdown;
      restart_sequence <= shut_leave && (rate_q != 8'h00);
      touch_enable <= ts_on && !alarm_q && !rst_busy;
      prox_enable <= px_on && !alarm_q && !rst_busy;
      haptics_enable <= hp_on && !alarm_q && !rst_busy;
    end
  end

  // interrupt sources
  logic [7:0] src_q, src_evt, src_vis;
  logic data_hold, src_clr;
  assign src_evt = {2'b00, short_event, prox_event, data_ready_event,
                    pen_event, alarm_rise, warn_rise};
  assign src_vis = src_q & mask_q;
  assign data_hold = src_vis[tis_pkg::SRC_DATA]
                   && ((cfg.op_mode == tis_pkg::MODE_MANUAL)
                   || (cfg.op_mode == tis_pkg::MODE_PEN_TRIG));
  assign src_clr = data_hold ? chan_data_read_done : (rd_en && sel_src);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_q <= '0;
    end else if (rst_busy) begin
      src_q <= '0;
    end else begin
      // accumulate; a new event beats the clear
      src_q <= (src_clr ? 8'h00 : src_q) | src_evt;
    end
  end

  // status summary
  logic rflag_q;
  logic [7:0] stat_vis;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rflag_q <= 1'b0;
    end else if (flag_set) begin
      rflag_q <= 1'b1;
    end else if (rd_en && sel_stat) begin
      rflag_q <= 1'b0;
    end
  end
  assign stat_vis = {rflag_q, 2'b00, short_status && hp_on,
                     prox_status && px_on, pen_status && ts_on,
                     alarm_q, warn_q};

  // interrupt pin and adc halt
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      host_interrupt_n <= 1'b0;
      adc_halt <= 1'b0;
    end else begin
      host_interrupt_n <= !(rst_busy || rst_req || (|src_vis));
      adc_halt <= data_hold;
    end
  end

  // aux pins; the five_wire_sense and proximity paths get one flop of delay
  tis_pkg::tis_aux_s aux_cfg [3];
  logic [15:0] aux_bits;
  logic [2:0] aux_alt;
  logic [2:0] aux_d;
  assign aux_cfg[0] = tis_pkg::tis_aux_s'({aux_pin_one_q[5:4], aux0_q[3:0]});
  assign aux_cfg[1] = tis_pkg::tis_aux_s'({aux_pin_one_q[7:6], aux0_q[7:4]});
  assign aux_cfg[2] = tis_pkg::tis_aux_s'({2'b00, aux_pin_one_q[3:0]});
  assign aux_bits = {src_vis, stat_vis};
  assign aux_alt = {prox_shield_route, prox_sensor_route, five_wire_sense};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_aux
      assign aux_d[gi] =
        (aux_cfg[gi].func == tis_pkg::AUX_FIVE_WIRE_SENSE) ? (gi == 0) & aux_alt[0] :
        (aux_cfg[gi].func == tis_pkg::AUX_PSENSE) ? aux_alt[1] :
        (aux_cfg[gi].func == tis_pkg::AUX_PSHIELD) ? aux_alt[2] :
        aux_bits[aux_cfg[gi].sel];
    end
  endgenerate
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aux_pin_one <= 1'b0;
      aux_pin_two <= 1'b0;
      aux_pin_three <= 1'b0;
    end else begin
      aux_pin_one <= aux_d[0];
      aux_pin_two <= aux_d[1];
      aux_pin_three <= aux_d[2];
    end
  end

  // apb read data; no wait state, prdata and pready are registered during the setup phase
  logic [7:0] rd_mux;
  assign rd_mux = sel_mask ? mask_q :
                  sel_src ? src_vis :
                  sel_stat ? stat_vis :
                  sel_cfg ? cfg_raw_q :
                  sel_rate ? rate_q :
                  sel_aux0 ? aux0_q :
                  sel_aux_pin_one ? aux_pin_one_q : 8'h00;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= {24'h000000, pwrite ? 8'h00 : rd_mux};
      pready <= 1'b1;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ==== rtl/tis_pkg.sv ====
package tis_pkg;
  // clock and slow oscillator
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_OSC_HZ = 32_768;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  localparam int unsigned DIV_W = 11;
  localparam logic [DIV_W-1:0] SLOW_DIV_LAST = DIV_W'(SLOW_DIV - 1);
  localparam int unsigned TEMP_TICKS = 1024;
  localparam logic [9:0] TEMP_TICK_LAST = 10'(TEMP_TICKS - 1);
  localparam int unsigned RESET_TICKS_DEF = 64;
  // thermal levels in degrees C
  localparam logic [7:0] WARN_LEVEL_C = 8'h78;
  localparam logic [7:0] ALARM_LEVEL_C = 8'h9B;
  // register byte offsets
  localparam logic [7:0] OFS_IRQ_MASK = 8'h00;
  localparam logic [7:0] OFS_IRQ_SRC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SOFT_RST = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_RATE = 8'h14;
  localparam logic [7:0] OFS_AUX0 = 8'h18;
  localparam logic [7:0] OFS_AUX_PIN_ONE = 8'h1C;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hDE;
  // reset values
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] AUX0_RST = 8'h00;
  localparam logic [7:0] AUX_PIN_ONE_RST = 8'h00;
  // source bits
  localparam int unsigned SRC_WARN = 0;
  localparam int unsigned SRC_ALARM = 1;
  localparam int unsigned SRC_PEN = 2;
  localparam int unsigned SRC_DATA = 3;
  localparam int unsigned SRC_PROX = 4;
  localparam int unsigned SRC_SHORT = 5;
  // status bits
  localparam int unsigned ST_WARN = 0;
  localparam int unsigned ST_ALARM = 1;
  localparam int unsigned ST_PEN = 2;
  localparam int unsigned ST_PROX = 3;
  localparam int unsigned ST_SHORT = 4;
  localparam int unsigned ST_RESET = 7;
  // operating modes
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_PEN_DET = 2'h1;
  localparam logic [1:0] MODE_PEN_TRIG = 2'h2;
  // aux routing codes
  localparam logic [1:0] AUX_BIT = 2'h0;
  localparam logic [1:0] AUX_FIVE_WIRE_SENSE = 2'h1;
  localparam logic [1:0] AUX_PSENSE = 2'h2;
  localparam logic [1:0] AUX_PSHIELD = 2'h3;

  typedef struct packed {
    logic [1:0] actuator_type_select;
    logic [2:0] proximity_scan_interval;
    logic [1:0] op_mode;
    logic thermal_monitor_continuous;
  } tis_cfg_s;

  typedef struct packed {
    logic [1:0] func;
    logic [3:0] sel;
  } tis_aux_s;

  typedef enum logic [1:0] {TS_WAIT, TS_PEND, TS_MEAS} tis_temp_e;
  typedef enum logic [1:0] {RS_RUN, RS_HOLD, RS_COUNT} tis_rst_e;
endpackage

// ==== verif/tis_properties.sv ====
`timescale 1ns/1ps
module tis_properties #(
  parameter int unsigned RESET_TICKS = tis_pkg::RESET_TICKS_DEF
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_reset_n,
  input wire logic esd_event,
  input wire logic host_interrupt_n,
  input wire logic temp_start,
  input wire logic thermal_shutdown,
  input wire logic discard_results,
  input wire logic touch_enable,
  input wire logic prox_enable,
  input wire logic haptics_enable
);
  // small slack for the divider phase at release
  localparam int unsigned HOLD_MIN = RESET_TICKS * tis_pkg::SLOW_DIV - 4;
  logic [31:0] up_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      up_q <= 32'h00000000;
    end else if (up_q != 32'hFFFFFFFF) begin
      up_q <= up_q + 32'h00000001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_por_hold: assert property (
    host_interrupt_n |-> up_q >= HOLD_MIN)
    else $error("interrupt released before reset procedure end");
  chk_pin_reset: assert property (
    !external_reset_n [*5] |-> !host_interrupt_n)
    else $error("reset pin did not pull interrupt low");
  chk_esd_reset: assert property (
    esd_event |-> ##[1:2] !host_interrupt_n)
    else $error("esd reset did not pull interrupt low");
  chk_soft_reset: assert property (
    psel && penable && pready && pwrite &&
    paddr == tis_pkg::OFS_SOFT_RST &&
    pwdata[7:0] == tis_pkg::SOFT_RESET_KEY |-> ##[1:2] !host_interrupt_n)
    else $error("soft reset did not pull interrupt low");
  chk_shutdown_off: assert property (
    thermal_shutdown |-> !touch_enable && !prox_enable && !haptics_enable)
    else $error("function enabled during shutdown");
  chk_discard_entry: assert property (
    discard_results |-> ##[0:1] thermal_shutdown)
    else $error("discard outside shutdown entry");
  chk_start_pulse: assert property (temp_start |=> !temp_start)
    else $error("measurement start longer than one cycle");
endmodule
bind tis_supervisor tis_properties #(.RESET_TICKS(RESET_TICKS)) u_props (.*);

// ==== verif/tis_temp_sensor.sv ====
`timescale 1ns/1ps
module tis_temp_sensor #(
  parameter int LAT = 40
) (
  input wire logic clock,
  input wire logic [7:0] die_c,
  input wire logic resetn,
  input wire logic temp_start,
  output logic temp_done,
  output logic [7:0] temp_celsius
);
  int cnt_q;
  // result lines toggle between conversions so stale data never looks valid
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 0;
      temp_done <= 1'b0;
      temp_celsius <= 8'h00;
    end else begin
      temp_done <= (cnt_q == 1);
      temp_celsius <= (cnt_q == 1) ? die_c : ~temp_celsius;
      if (temp_start) begin
        cnt_q <= LAT;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, host_interrupt_n, aux_pin_one, adc_halt;
  logic temp_start, temp_done, external_reset_n = 1, adc_busy = 0;
  logic [7:0] temp_celsius, r;
  logic [5:0] ev = 6'h00;
  logic five_wire_sense = 0, tie0 = 0, pen_st = 1;
  logic thermal_shutdown, touch_enable, haptics_enable;
  logic discard_results, restart_sequence;
  logic [7:0] die_c = 8'h19, n_disc = 8'h00, n_rest = 8'h00;
  int bad_count = 0, n_compared = 0, cycles = 0;
  integer seed = 32'h6b1b;
  logic [32:0] exp_q[$];
  always #10 clock = ~clock;
  tis_supervisor #(.RESET_TICKS(2), .TEMP_TICKS(2)) dut (.clock(clock),
    .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_n(external_reset_n), .esd_event(ev[5]),
    .adc_busy(adc_busy), .temp_done(temp_done), .temp_celsius(temp_celsius),
    .pen_event(ev[0]), .data_ready_event(ev[1]), .prox_event(ev[2]),
    .short_event(ev[3]), .pen_status(pen_st), .prox_status(tie0),
    .short_status(tie0), .chan_data_read_done(ev[4]),
    .five_wire_sense(five_wire_sense), .prox_sensor_route(tie0),
    .prox_shield_route(tie0), .host_interrupt_n(host_interrupt_n),
    .temp_start(temp_start), .thermal_shutdown(thermal_shutdown),
    .discard_results(discard_results),
    .restart_sequence(restart_sequence), .touch_enable(touch_enable),
    .prox_enable(), .haptics_enable(haptics_enable), .adc_halt(adc_halt),
    .aux_pin_one(aux_pin_one),
    .aux_pin_two(), .aux_pin_three());
  tis_temp_sensor u_sens (.clock(clock), .resetn(resetn),
    .die_c(die_c), .temp_start(temp_start), .temp_done(temp_done),
    .temp_celsius(temp_celsius));
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
      input logic [32:0] e);
    @(posedge clock);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'($random(seed)), d};
    if (!w) exp_q.push_back(e);
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b0, 8'h00, {25'h0, d});
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1;
    @(posedge clock);
    ev[i] <= 0;
  endtask
  task automatic pin(input logic want);
    repeat (3) @(posedge clock);
    #1 check(host_interrupt_n, want);
  endtask
  task automatic wait_hi();
    while (host_interrupt_n !== 1'b1) @(posedge clock);
  endtask
  always @(posedge clock) begin
    adc_busy <= 1'($random(seed));
    if (discard_results) n_disc <= n_disc + 8'h01;
    if (restart_sequence) n_rest <= n_rest + 8'h01;
    if (psel && penable && pready && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1;
    #1 check(host_interrupt_n, 1'b0);
    wait_hi();
    rd(tis_pkg::OFS_STATUS, 8'h00);
    rd(tis_pkg::OFS_IRQ_MASK, tis_pkg::IRQ_MASK_RST);
    rd(tis_pkg::OFS_CFG, tis_pkg::CFG_RST);
    rd(tis_pkg::OFS_AUX0, tis_pkg::AUX0_RST);
    rd(tis_pkg::OFS_AUX_PIN_ONE, tis_pkg::AUX_PIN_ONE_RST);
    apb(8'h20, 1'b0, 8'h00, {1'b1, 32'h0});
    r = 8'($random(seed));
    wr(tis_pkg::OFS_RATE, r);
    rd(tis_pkg::OFS_RATE, r);
    wr(tis_pkg::OFS_IRQ_MASK, r);
    rd(tis_pkg::OFS_IRQ_MASK, r);
    wr(tis_pkg::OFS_IRQ_MASK, 8'h2C);
    pulse(0);
    pin(1'b0);
    pulse(3);
    pulse(2);
    rd(tis_pkg::OFS_IRQ_SRC, 8'h24);
    pin(1'b1);
    pulse(2);
    pin(1'b1);
    rd(tis_pkg::OFS_IRQ_SRC, 8'h00);
    for (int m = 0; m < 3; m++) begin
      wr(tis_pkg::OFS_CFG, {5'h00, 2'(m), 1'b0});
      rd(tis_pkg::OFS_CFG, {5'h00, 2'(m), 1'b0});
      rd(tis_pkg::OFS_STATUS, {5'h00, m != 0, 2'b00});
      pulse(1);
      pin(1'b0);
      rd(tis_pkg::OFS_IRQ_SRC, 8'h08);
      pin(m == 1);
      check(adc_halt, m != 1);
      pulse(4);
      pin(1'b1);
    end
    wr(tis_pkg::OFS_AUX_PIN_ONE, 8'h10);
    five_wire_sense <= 1;
    repeat (3) @(posedge clock);
    #1 check(aux_pin_one, 1'b1);
    @(posedge clock);
    five_wire_sense <= 0;
    repeat (3) @(posedge clock);
    #1 check(aux_pin_one, 1'b0);
    die_c <= 8'h9C;
    wr(tis_pkg::OFS_IRQ_MASK, 8'h03);
    wr(tis_pkg::OFS_CFG, 8'h44);
    while (host_interrupt_n !== 1'b0) @(posedge clock);
    rd(tis_pkg::OFS_IRQ_SRC, 8'h03);
    rd(tis_pkg::OFS_STATUS, 8'h07);
    die_c <= 8'h19;
    #1 check({thermal_shutdown, touch_enable, haptics_enable}, 3'h4);
    while (thermal_shutdown !== 1'b0) @(posedge clock);
    // restart_sequence pulses once on shutdown exit only if the rate register r is non-zero
    #1 check({thermal_shutdown, touch_enable, haptics_enable}, 3'h3);
    check(n_disc, 8'h01);
    check(n_rest, r != 8'h00);
    // mask holds no live source, so only the reset can pull the pin
    for (int k = 0; k < 3; k++) begin
      wr(tis_pkg::OFS_IRQ_MASK, 8'hC0);
      @(posedge clock);
      if (k == 0) external_reset_n <= 0;
      if (k == 1) ev[5] <= 1;
      if (k == 2) wr(tis_pkg::OFS_SOFT_RST, tis_pkg::SOFT_RESET_KEY);
      @(posedge clock);
      ev[5] <= 0;
      pin(1'b0);
      @(posedge clock);
      external_reset_n <= 1;
      wait_hi();
      rd(tis_pkg::OFS_IRQ_MASK, tis_pkg::IRQ_MASK_RST);
      rd(tis_pkg::OFS_STATUS, 8'h80);
      rd(tis_pkg::OFS_STATUS, 8'h00);
    end
    repeat (2) @(posedge clock);
    end_sim();
  end
endmodule
